//--- src/cc_pkg.sv
package cc_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 50;
    localparam int DRP_PERIOD_NS = 75_000_000;
    localparam int DRP_HALF_CYCLES = DRP_PERIOD_NS / 2 / CLK_PERIOD_NS;
    localparam int CC_DEBOUNCE_NS = 100_000;
    localparam int CC_DEBOUNCE_CYCLES =
        (CC_DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ----------------------------------------------------------------
    // Register offsets and reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] CTRL_OFF = 8'h00;
    localparam logic [7:0] CMD_OFF = 8'h04;
    localparam logic [7:0] STATUS_OFF = 8'h08;
    localparam logic [7:0] IRQ_OFF = 8'h0c;
    localparam logic [7:0] IRQ_EN_OFF = 8'h10;
    localparam logic [7:0] GPIO_OFF = 8'h14;
    localparam logic [11:0] CTRL_RESET = 12'h200;
    localparam logic [3:0] IRQ_EN_RESET = 4'hf;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_TRY_SNK = 2;
    localparam int CTRL_AUDIO_EN = 3;
    localparam int CTRL_DEBUG_EN = 4;
    localparam int CTRL_ADV_LSB = 5;
    localparam int CTRL_AUTO_1P5 = 7;
    localparam int CTRL_ADV3_ALLOW = 8;
    localparam int CTRL_MOIST_EN = 9;
    localparam int CTRL_ILIM_EN = 10;
    localparam int CTRL_SUPERSPEED = 11;
    localparam int CMD_PR_SWAP = 0;
    localparam int CMD_VCONN_SWAP = 1;
    localparam int IRQ_ATTACH = 0;
    localparam int IRQ_DETACH = 1;
    localparam int IRQ_ADV_CHANGE = 2;
    localparam int IRQ_ERROR = 3;
    localparam int GPIO_OUT_LSB = 0;
    localparam int GPIO_OE_LSB = 3;
    localparam int GPIO_IN_LSB = 6;
    localparam int GPIO_STRAP_OUT = 9;
    localparam int GPIO_STRAP_OE = 10;

    // ----------------------------------------------------------------
    // Sink power objects, lowest power first
    // ----------------------------------------------------------------
    localparam int SINK_PDO_MV [3] = '{5000, 9000, 15000};
    localparam int SINK_PDO_MA = 3000;

    // ----------------------------------------------------------------
    // Encodings
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_DRP = 2'b00,
        MODE_SRC = 2'b01,
        MODE_SNK = 2'b10
    } mode_t;

    // Sense code seen while presenting pull-ups.
    localparam logic [1:0] SRC_OPEN = 2'h0;
    localparam logic [1:0] SRC_RA = 2'h1;
    localparam logic [1:0] SRC_RD = 2'h2;

    // Sense code seen while presenting pull-downs, also the current level.
    typedef enum logic [1:0] {
        ADV_NONE = 2'b00,
        ADV_DEFAULT = 2'b01,
        ADV_1P5 = 2'b10,
        ADV_3P0 = 2'b11
    } adv_t;

    typedef enum logic [1:0] {
        CONN_NONE = 2'b00,
        CONN_SOURCE = 2'b01,
        CONN_SINK = 2'b10,
        CONN_ACCESSORY = 2'b11
    } conn_t;

    typedef enum logic [2:0] {
        ST_UNATT_SRC = 3'b000,
        ST_UNATT_SNK = 3'b001,
        ST_ATT_SRC = 3'b010,
        ST_ATT_SNK = 3'b011,
        ST_TRY_SNK = 3'b100,
        ST_ACC = 3'b101
    } cc_state_t;

endpackage

//--- src/cc_filter.sv
`timescale 1ns/1ps

module cc_filter #(
    parameter int CYCLES = 2000
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic restart,
    input wire logic [1:0] raw,
    output logic [1:0] stable
);

    typedef struct packed {
        logic [15:0] cnt;
        logic [1:0] cand;
        logic [1:0] stable;
    } filt_t;

    filt_t s;
    filt_t next_s;

    // A level is taken only after it stays unchanged for CYCLES clocks.
    always_comb begin
        next_s = s;
        if (restart || raw != s.cand) begin
            next_s.cand = raw;
            next_s.cnt = 16'h0000;
        end else if (s.cnt == 16'(CYCLES - 1)) begin
            next_s.stable = s.cand;
        end else begin
            next_s.cnt = s.cnt + 16'h0001;
        end
        if (restart) begin
            next_s.stable = 2'h0;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign stable = s.stable;

endmodule

//--- src/cc_timer.sv
`timescale 1ns/1ps

module cc_timer #(
    parameter int CYCLES = 750000
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic restart,
    output logic expire
);

    typedef struct packed {
        logic [23:0] cnt;
        logic expire;
    } tmr_t;

    tmr_t s;
    tmr_t next_s;

    // Free-running interval timer; a restart begins a full interval.
    always_comb begin
        next_s = s;
        next_s.expire = 1'b0;
        if (restart || s.cnt == 24'(CYCLES - 1)) begin
            next_s.cnt = 24'h000000;
            next_s.expire = !restart;
        end else begin
            next_s.cnt = s.cnt + 24'h000001;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign expire = s.expire;

endmodule

//--- src/cc_manager.sv
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps


module cc_manager #(
    parameter int DRP_HALF = cc_pkg::DRP_HALF_CYCLES,
    parameter int DEBOUNCE = cc_pkg::CC_DEBOUNCE_CYCLES
) (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic PREADY,
    output logic [31:0] PRDATA,
    output logic PSLVERR,
    input wire logic [1:0] CC1_SENSE,
    input wire logic [1:0] CC2_SENSE,
    output logic PRESENT_RP,
    output logic [1:0] RP_LEVEL,
    output logic VCONN_CC1,
    output logic VCONN_CC2,
    output logic LOCAL_SINK,
    input wire logic [2:0] SRC_PDO_MATCH,
    output logic [1:0] SEL_PDO,
    output logic PR_SWAP_REQ,
    output logic VCONN_SWAP_REQ,
    output logic [1:0] CHG_ILIM,
    output logic CHG_ILIM_LOAD,
    output logic HOST_IRQ_N_O,
    output logic HOST_IRQ_N_OE,
    input wire logic TARGET_ID_STRAP_PIN_I,
    output logic TARGET_ID_STRAP_PIN_O,
    output logic TARGET_ID_STRAP_PIN_OE,
    output logic TARGET_BUS_ID,
    input wire logic [2:0] GPIO_I,
    output logic [2:0] GPIO_O,
    output logic [2:0] GPIO_OE,
    output logic MOIST_ACTIVE
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        cc_pkg::cc_state_t st;
        logic cc_sel;
        logic [1:0] partner_adv;
        logic vconn1;
        logic vconn2;
        logic error;
        cc_pkg::conn_t conn;
        logic [11:0] ctrl;
        logic [3:0] irq;
        logic [3:0] irq_en;
        logic [10:0] gpio;
        logic strap_done;
        logic target_id;
        logic present_rp;
        logic local_sink;
        logic [2:0] gpio_oe;
        logic tried;
        logic [1:0] rp_level;
        logic [1:0] sel_pdo;
        logic pr_swap;
        logic vconn_swap;
        logic [1:0] ilim;
        logic ilim_load;
        logic irq_oe;
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
    } mgr_t;

    mgr_t s;
    mgr_t next_s;
    logic [1:0] d1;
    logic [1:0] d2;
    logic expire;
    logic filt_restart;
    logic tmr_restart;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [1:0] top_pdo(input logic [2:0] m);
        top_pdo = 2'h0;
        for (int i = 0; i < 3; i++) begin
            if (m[i]) begin
                top_pdo = 2'(i + 1);
            end
        end
    endfunction

    function automatic logic [1:0] own_adv(input logic [11:0] c);
        logic [1:0] req;
        req = c[cc_pkg::CTRL_ADV_LSB +: 2];
        own_adv = cc_pkg::ADV_DEFAULT;
        if (req == cc_pkg::ADV_3P0 && c[cc_pkg::CTRL_ADV3_ALLOW]) begin
            own_adv = cc_pkg::ADV_3P0;
        end else if (req != cc_pkg::ADV_DEFAULT &&
            req != cc_pkg::ADV_NONE) begin
            own_adv = cc_pkg::ADV_1P5;
        end else if (c[cc_pkg::CTRL_AUTO_1P5]) begin
            own_adv = cc_pkg::ADV_1P5;
        end
    endfunction

    function automatic logic is_attached(input cc_pkg::cc_state_t x);
        is_attached = x == cc_pkg::ST_ATT_SRC || x == cc_pkg::ST_ATT_SNK ||
            x == cc_pkg::ST_ACC;
    endfunction

    // ----------------------------------------------------------------
    // CC filtering and toggle timing
    // ----------------------------------------------------------------
    cc_filter #(.CYCLES(DEBOUNCE)) u_filt1 (
        .clk(CLK),
        .reset_n(RESET_N),
        .restart(filt_restart),
        .raw(CC1_SENSE),
        .stable(d1)
    );

    cc_filter #(.CYCLES(DEBOUNCE)) u_filt2 (
        .clk(CLK),
        .reset_n(RESET_N),
        .restart(filt_restart),
        .raw(CC2_SENSE),
        .stable(d2)
    );

    // The same interval serves both the toggle half period and the
    // sink-preference trial window.
    cc_timer #(.CYCLES(DRP_HALF)) u_tmr (
        .clk(CLK),
        .reset_n(RESET_N),
        .restart(tmr_restart),
        .expire(expire)
    );

    assign filt_restart = next_s.present_rp != s.present_rp;
    assign tmr_restart = next_s.st != s.st;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        logic [1:0] act;
        logic [1:0] oth;
        logic [1:0] mode;
        logic drp;
        logic rd1;
        logic rd2;
        logic ra1;
        logic ra2;
        logic [3:0] ev;
        logic [3:0] clr;
        logic rd_go;
        logic wr_go;
        act = s.cc_sel ? d2 : d1;
        oth = s.cc_sel ? d1 : d2;
        mode = s.ctrl[cc_pkg::CTRL_MODE_LSB +: 2];
        drp = mode == cc_pkg::MODE_DRP;
        rd1 = d1 == cc_pkg::SRC_RD;
        rd2 = d2 == cc_pkg::SRC_RD;
        ra1 = d1 == cc_pkg::SRC_RA;
        ra2 = d2 == cc_pkg::SRC_RA;
        ev = 4'h0;
        clr = 4'h0;
        rd_go = PSEL && PENABLE && s.pready && !PWRITE;
        wr_go = PSEL && PENABLE && s.pready && PWRITE;
        next_s = s;
        next_s.pr_swap = 1'b0;
        next_s.vconn_swap = 1'b0;
        next_s.ilim_load = 1'b0;

        // Connection state machine.
        case (s.st)
            cc_pkg::ST_UNATT_SRC: begin
                if (rd1 && rd2) begin
                    if (s.ctrl[cc_pkg::CTRL_DEBUG_EN]) begin
                        next_s.st = cc_pkg::ST_ACC;
                    end else begin
                        next_s.error = 1'b1;
                    end
                end else if (ra1 && ra2) begin
                    if (s.ctrl[cc_pkg::CTRL_AUDIO_EN]) begin
                        next_s.st = cc_pkg::ST_ACC;
                    end else begin
                        next_s.error = 1'b1;
                    end
                end else if (rd1 || rd2) begin
                    next_s.cc_sel = rd2;
                    // After one failed sink trial the next Rd attaches as
                    // source, so a plain sink partner is not lost.
                    if (drp && s.ctrl[cc_pkg::CTRL_TRY_SNK] &&
                        !s.tried) begin
                        next_s.st = cc_pkg::ST_TRY_SNK;
                        next_s.tried = 1'b1;
                    end else begin
                        next_s.st = cc_pkg::ST_ATT_SRC;
                    end
                end else if (mode == cc_pkg::MODE_SNK ||
                    (drp && expire)) begin
                    next_s.st = cc_pkg::ST_UNATT_SNK;
                end
            end
            cc_pkg::ST_UNATT_SNK: begin
                if (d1 != cc_pkg::ADV_NONE && d2 != cc_pkg::ADV_NONE) begin
                    if (s.ctrl[cc_pkg::CTRL_DEBUG_EN]) begin
                        next_s.st = cc_pkg::ST_ACC;
                    end
                end else if (d1 != cc_pkg::ADV_NONE ||
                    d2 != cc_pkg::ADV_NONE) begin
                    next_s.cc_sel = d2 != cc_pkg::ADV_NONE;
                    next_s.st = cc_pkg::ST_ATT_SNK;
                end else if (mode == cc_pkg::MODE_SRC ||
                    (drp && expire)) begin
                    next_s.st = cc_pkg::ST_UNATT_SRC;
                end
            end
            cc_pkg::ST_TRY_SNK: begin
                if (d1 != cc_pkg::ADV_NONE || d2 != cc_pkg::ADV_NONE) begin
                    next_s.cc_sel = d2 != cc_pkg::ADV_NONE;
                    next_s.st = cc_pkg::ST_ATT_SNK;
                end else if (expire) begin
                    // A partner that also prefers sink may land either way.
                    next_s.st = cc_pkg::ST_UNATT_SRC;
                end
            end
            cc_pkg::ST_ATT_SRC: begin
                if (act != cc_pkg::SRC_RD) begin
                    next_s.st = cc_pkg::ST_UNATT_SRC;
                end
            end
            cc_pkg::ST_ATT_SNK: begin
                if (act == cc_pkg::ADV_NONE) begin
                    next_s.st = mode == cc_pkg::MODE_SNK ?
                        cc_pkg::ST_UNATT_SNK : cc_pkg::ST_UNATT_SRC;
                end else if (act != s.partner_adv) begin
                    next_s.partner_adv = act;
                    ev[cc_pkg::IRQ_ADV_CHANGE] = 1'b1;
                    next_s.ilim_load = s.ctrl[cc_pkg::CTRL_ILIM_EN];
                end
            end
            cc_pkg::ST_ACC: begin
                if (d1 == 2'h0 || d2 == 2'h0 || d1 != d2) begin
                    next_s.st = cc_pkg::ST_UNATT_SRC;
                end
            end
            default: begin
                next_s.st = cc_pkg::ST_UNATT_SRC;
            end
        endcase

        // The trial mark lasts only across one source-trial-source pass.
        if (next_s.st != cc_pkg::ST_UNATT_SRC &&
            next_s.st != cc_pkg::ST_TRY_SNK) begin
            next_s.tried = 1'b0;
        end

        // Attach and detach side effects.
        if (is_attached(next_s.st) && !is_attached(s.st)) begin
            ev[cc_pkg::IRQ_ATTACH] = 1'b1;
            next_s.error = 1'b0;
            if (next_s.st == cc_pkg::ST_ATT_SNK) begin
                next_s.partner_adv = next_s.cc_sel ? d2 : d1;
                next_s.ilim_load = s.ctrl[cc_pkg::CTRL_ILIM_EN];
                next_s.conn = cc_pkg::CONN_SOURCE;
            end else if (next_s.st == cc_pkg::ST_ATT_SRC) begin
                next_s.conn = cc_pkg::CONN_SINK;
            end else begin
                next_s.conn = cc_pkg::CONN_ACCESSORY;
            end
        end
        if (!is_attached(next_s.st) && is_attached(s.st)) begin
            ev[cc_pkg::IRQ_DETACH] = 1'b1;
            next_s.conn = cc_pkg::CONN_NONE;
            next_s.partner_adv = cc_pkg::ADV_NONE;
        end
        if (next_s.error && !s.error) begin
            ev[cc_pkg::IRQ_ERROR] = 1'b1;
        end

        // Cable power goes to the line that carries Ra.
        oth = next_s.cc_sel ? d1 : d2;
        next_s.vconn1 = next_s.st == cc_pkg::ST_ATT_SRC && next_s.cc_sel &&
            oth == cc_pkg::SRC_RA;
        next_s.vconn2 = next_s.st == cc_pkg::ST_ATT_SRC && !next_s.cc_sel &&
            oth == cc_pkg::SRC_RA;

        // Pin presentation follows the state.
        next_s.present_rp = next_s.st == cc_pkg::ST_UNATT_SRC ||
            next_s.st == cc_pkg::ST_ATT_SRC || next_s.st == cc_pkg::ST_ACC;
        next_s.local_sink = !next_s.present_rp;
        next_s.rp_level = own_adv(s.ctrl);
        next_s.sel_pdo = next_s.st == cc_pkg::ST_ATT_SNK ?
            top_pdo(SRC_PDO_MATCH) : 2'h0;
        next_s.ilim = next_s.partner_adv;

        // Strap capture on the first edge after reset release.
        if (!s.strap_done) begin
            next_s.strap_done = 1'b1;
            next_s.target_id = TARGET_ID_STRAP_PIN_I;
        end

        // Register bus.
        next_s.pready = PSEL && !PENABLE;
        // The error flag stands only in the cycle that carries ready.
        next_s.pslverr = 1'b0;
        if (PSEL && !PENABLE) begin
            next_s.prdata = 32'h00000000;
            case (PADDR)
                cc_pkg::CTRL_OFF: begin
                    next_s.prdata = {20'h00000, s.ctrl};
                end
                cc_pkg::CMD_OFF: begin
                    next_s.prdata = 32'h00000000;
                end
                cc_pkg::STATUS_OFF: begin
                    next_s.prdata = {19'h00000, s.target_id,
                        s.sel_pdo, s.error, s.rp_level, s.partner_adv,
                        s.vconn1 | s.vconn2, s.cc_sel, s.local_sink,
                        s.conn};
                end
                cc_pkg::IRQ_OFF: begin
                    next_s.prdata = {28'h0000000, s.irq};
                end
                cc_pkg::IRQ_EN_OFF: begin
                    next_s.prdata = {28'h0000000, s.irq_en};
                end
                cc_pkg::GPIO_OFF: begin
                    next_s.prdata = {21'h000000, s.gpio[10:9], GPIO_I,
                        s.gpio[5:0]};
                end
                default: begin
                    next_s.pslverr = 1'b1;
                end
            endcase
        end
        if (wr_go) begin
            case (PADDR)
                cc_pkg::CTRL_OFF: begin
                    next_s.ctrl = PWDATA[11:0];
                end
                cc_pkg::CMD_OFF: begin
                    next_s.pr_swap = PWDATA[cc_pkg::CMD_PR_SWAP];
                    next_s.vconn_swap = PWDATA[cc_pkg::CMD_VCONN_SWAP];
                end
                cc_pkg::IRQ_EN_OFF: begin
                    next_s.irq_en = PWDATA[3:0];
                end
                cc_pkg::GPIO_OFF: begin
                    next_s.gpio = {PWDATA[10:9], 3'h0, PWDATA[5:0]};
                end
                default: begin
                end
            endcase
        end
        if (rd_go && PADDR == cc_pkg::IRQ_OFF) begin
            // Only the bits that were reported are cleared.
            clr = s.prdata[3:0];
        end
        // A new event in the clearing cycle survives.
        next_s.irq = (s.irq & ~clr) | ev;
        next_s.irq_oe = |(next_s.irq & next_s.irq_en);
        // Moisture sensing owns the pins, so their drivers stay off.
        next_s.gpio_oe = next_s.ctrl[cc_pkg::CTRL_MOIST_EN] ? 3'h0 :
            next_s.gpio[cc_pkg::GPIO_OE_LSB +: 3];
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            s <= '0;
            s.ctrl <= cc_pkg::CTRL_RESET;
            s.irq_en <= cc_pkg::IRQ_EN_RESET;
        end else begin
            s <= next_s;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign PREADY = s.pready;
    assign PRDATA = s.prdata;
    assign PSLVERR = s.pslverr;
    assign PRESENT_RP = s.present_rp;
    assign RP_LEVEL = s.rp_level;
    assign VCONN_CC1 = s.vconn1;
    assign VCONN_CC2 = s.vconn2;
    assign LOCAL_SINK = s.local_sink;
    assign SEL_PDO = s.sel_pdo;
    assign PR_SWAP_REQ = s.pr_swap;
    assign VCONN_SWAP_REQ = s.vconn_swap;
    assign CHG_ILIM = s.ilim;
    assign CHG_ILIM_LOAD = s.ilim_load;
    assign HOST_IRQ_N_O = 1'b0;
    assign HOST_IRQ_N_OE = s.irq_oe;
    assign TARGET_BUS_ID = s.target_id;
    assign TARGET_ID_STRAP_PIN_O = s.gpio[cc_pkg::GPIO_STRAP_OUT];
    assign TARGET_ID_STRAP_PIN_OE = s.gpio[cc_pkg::GPIO_STRAP_OE];
    assign GPIO_O = s.gpio[cc_pkg::GPIO_OUT_LSB +: 3];
    assign GPIO_OE = s.gpio_oe;
    assign MOIST_ACTIVE = s.ctrl[cc_pkg::CTRL_MOIST_EN];

endmodule

//--- tb/cc_manager_props.sv
`timescale 1ns/1ps

module cc_manager_props (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic PRESENT_RP,
    input wire logic LOCAL_SINK,
    input wire logic VCONN_CC1,
    input wire logic VCONN_CC2,
    input wire logic [1:0] SEL_PDO,
    input wire logic PR_SWAP_REQ,
    input wire logic HOST_IRQ_N_O,
    input wire logic [2:0] GPIO_OE,
    input wire logic MOIST_ACTIVE
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    ready_after_setup_a: assert property (PSEL && !PENABLE |=> PREADY)
        else $error("no answer after setup");
    error_with_ready_a: assert property (PSLVERR |-> PREADY)
        else $error("error without ready");
    irq_drive_low_a: assert property (HOST_IRQ_N_O == 1'b0)
        else $error("interrupt pin driven high");
    role_follow_a: assert property ($fell(PRESENT_RP) |-> LOCAL_SINK)
        else $error("power role not sink");
    role_exclusive_a: assert property (!(PRESENT_RP && LOCAL_SINK))
        else $error("source and sink at once");
    cable_power_a: assert property (VCONN_CC1 || VCONN_CC2 |-> PRESENT_RP)
        else $error("cable power while sink");
    cable_one_pin_a: assert property (!(VCONN_CC1 && VCONN_CC2))
        else $error("cable power on both pins");
    pdo_sink_only_a: assert property (SEL_PDO != 2'h0 |-> LOCAL_SINK)
        else $error("power object chosen while source");
    swap_pulse_a: assert property (PR_SWAP_REQ |=> !PR_SWAP_REQ)
        else $error("swap request held");
    moist_pins_a: assert property (MOIST_ACTIVE |-> GPIO_OE == 3'h0)
        else $error("pin driven during moisture use");
endmodule

bind cc_manager cc_manager_props props_u (.CLK(CLK), .RESET_N(RESET_N),
    .PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .PRESENT_RP(PRESENT_RP), .LOCAL_SINK(LOCAL_SINK), .SEL_PDO(SEL_PDO),
    .VCONN_CC1(VCONN_CC1), .VCONN_CC2(VCONN_CC2), .GPIO_OE(GPIO_OE),
    .PR_SWAP_REQ(PR_SWAP_REQ), .HOST_IRQ_N_O(HOST_IRQ_N_O),
    .MOIST_ACTIVE(MOIST_ACTIVE));

//--- tb/cc_partner.sv
`timescale 1ns/1ps

module cc_partner (
    input wire logic present_rp,
    input wire logic [1:0] role,
    input wire logic [1:0] adv,
    output logic [1:0] cc1,
    output logic [1:0] cc2
);
    // Role 1 is a sink with an active cable, role 2 a source on CC2.
    always_comb begin
        cc1 = 2'h0;
        cc2 = 2'h0;
        if (role == 2'h1 && present_rp) begin
            cc1 = cc_pkg::SRC_RD;
            cc2 = cc_pkg::SRC_RA;
        end
        if (role == 2'h2 && !present_rp) begin
            cc2 = adv;
        end
    end
endmodule

//--- tb/typec_cc_connection_manager_tb_top.sv
`timescale 1ns/1ps

module typec_cc_connection_manager_tb_top;
    localparam int DH = 50;
    localparam logic [32:0] ALL = 33'h1_ffff_ffff;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, strap = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [2:0] pdo = 3'h0, gpio_i = 3'h0;
    logic [1:0] role = 2'h0, adv = 2'h1, cc1, cc2, sel;
    logic ready, slverr, rp, vc2, snk, prq, irq_oe, bus_id;
    logic [31:0] rdata;
    logic [32:0] exp_q[$], msk_q[$];
    int n_mismatch = 0, cmp_count = 0, t;

    cc_manager #(.DRP_HALF(DH), .DEBOUNCE(4)) dut_u (.CLK(clk),
        .RESET_N(reset_n), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PREADY(ready),
        .PRDATA(rdata), .PSLVERR(slverr), .CC1_SENSE(cc1),
        .CC2_SENSE(cc2), .PRESENT_RP(rp), .RP_LEVEL(), .VCONN_CC1(),
        .VCONN_CC2(vc2), .LOCAL_SINK(snk), .SRC_PDO_MATCH(pdo),
        .SEL_PDO(sel), .PR_SWAP_REQ(prq), .VCONN_SWAP_REQ(), .CHG_ILIM(),
        .CHG_ILIM_LOAD(), .HOST_IRQ_N_O(), .HOST_IRQ_N_OE(irq_oe),
        .TARGET_ID_STRAP_PIN_I(strap), .TARGET_ID_STRAP_PIN_O(),
        .TARGET_ID_STRAP_PIN_OE(), .TARGET_BUS_ID(bus_id),
        .GPIO_I(gpio_i), .GPIO_O(), .GPIO_OE(), .MOIST_ACTIVE());
    cc_partner partner_u (.present_rp(rp), .role(role), .adv(adv),
        .cc1(cc1), .cc2(cc2));

    initial begin
        forever #25 clk = ~clk;
    end

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test;
        $display("%0d mismatches in %0d compares", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (ready !== 1'b1) begin
            n++;
            if (n > 20) begin
                n_mismatch++;
                end_of_test();
            end
            @(posedge clk);
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [32:0] e,
                      input logic [32:0] m);
        exp_q.push_back(e);
        msk_q.push_back(m);
        apb(1'b0, a, 32'h0);
    endtask

    task automatic wait_for(input int k);
        for (int n = 0; n < 4 * DH; n++) begin
            @(posedge clk);
            if ((k == 0 && !rp) || (k == 1 && rp) || (k == 2 && vc2) ||
                (k == 3 && irq_oe) || (k == 4 && sel != 2'h0))
                return;
        end
        n_mismatch++;
        end_of_test();
    endtask

    // The monitor compares each read answer with the oldest note.
    always @(posedge clk) begin
        if (psel && penable && ready && !pwrite)
            check({slverr, rdata} & msk_q.pop_front(), exp_q.pop_front());
    end

    initial begin
        void'($urandom(32'he8951990));
        @(posedge clk);
        strap <= 1'($urandom);
        gpio_i <= 3'($urandom);
        repeat (9) @(posedge clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge clk);
        check({32'h0, bus_id}, {32'h0, strap});
        rd(cc_pkg::CTRL_OFF, 33'h200, ALL);
        rd(cc_pkg::IRQ_EN_OFF, 33'hf, ALL);
        rd(8'h18, 33'h1_0000_0000, ALL);
        rd(cc_pkg::GPIO_OFF, {24'h0, gpio_i, 6'h0}, 33'h1_0000_01c0);
        $display("reset test done");
        wait_for(0);
        wait_for(1);
        for (t = 0; rp === 1'b1 && t < 3 * DH; t++) @(posedge clk);
        check({32'h0, t >= DH - 1 && t <= DH + 1}, 33'h1);
        $display("toggle test done");
        apb(1'b1, cc_pkg::CTRL_OFF, 32'h1);
        wait_for(1);
        t = 0;
        repeat (2 * DH) begin
            @(posedge clk);
            t += int'(!rp);
        end
        check({1'b0, t}, 33'h0);
        role <= 2'h1;
        wait_for(2);
        check({32'h0, irq_oe}, 33'h1);
        rd(cc_pkg::STATUS_OFF, 33'h92, 33'h1_0000_019f);
        rd(cc_pkg::IRQ_OFF, 33'h1, 33'h1_0000_0001);
        @(posedge clk);
        check({32'h0, irq_oe}, 33'h0);
        apb(1'b1, cc_pkg::CMD_OFF, 32'h1);
        check({32'h0, prq}, 33'h1);
        role <= 2'h0;
        $display("source test done");
        apb(1'b1, cc_pkg::IRQ_EN_OFF, 32'h0);
        apb(1'b1, cc_pkg::CTRL_OFF, 32'h2);
        adv <= 2'($urandom_range(3, 1));
        pdo <= 3'($urandom_range(7, 1));
        role <= 2'h2;
        wait_for(4);
        repeat (2) @(posedge clk);
        check({32'h0, irq_oe}, 33'h0);
        check({31'h0, sel}, {31'h0, pdo[2] ? 2'h3 : pdo[1] ? 2'h2 : 2'h1});
        rd(cc_pkg::STATUS_OFF, {1'b0, 25'h0, adv, 5'h0d}, 33'h1_0000_007f);
        apb(1'b1, cc_pkg::IRQ_EN_OFF, 32'hf);
        wait_for(3);
        rd(cc_pkg::IRQ_OFF, 33'h1, 33'h1_0000_0001);
        adv <= (adv == 2'h3) ? 2'h1 : adv + 2'h1;
        wait_for(3);
        rd(cc_pkg::IRQ_OFF, 33'h4, 33'h1_0000_0004);
        role <= 2'h0;
        $display("sink test done");
        apb(1'b1, cc_pkg::CTRL_OFF, 32'h4);
        role <= 2'h1;
        wait_for(2);
        $display("sink preference test done");
        end_of_test();
    end
endmodule
